// ===== logic/cgs_defs.svh
// Register offsets, field positions, reset values and timing counts of the clock generator status block.
`ifndef CGS_DEFS_SVH
`define CGS_DEFS_SVH
// ==========================================================================
// Register byte offsets
`define CGS_OFS_STAT1 12'h000
`define CGS_OFS_STAT2 12'h004
`define CGS_OFS_FLTU 12'h008
`define CGS_OFS_FLTL 12'h00c
`define CGS_OFS_CTRL 12'h010
// ==========================================================================
// Field positions
`define CGS_BIT_IRQ 0
`define CGS_BIT_EXTGOOD 1
`define CGS_BIT_CLKLOSS 2
`define CGS_BIT_LOCK 3
`define CGS_BIT_LOCKLOSS 4
`define CGS_BIT_REFKIND 5
`define CGS_BIT_SETTLED 0
`define CGS_BIT_LOLCHOICE 2
`define CGS_BIT_LOCCHOICE 3
`define CGS_BIT_LOCDOFF 4
// ==========================================================================
// Reset values
`define CGS_RST_FILTER 12'h000
`define CGS_RST_CTRL 5'h00
// ==========================================================================
// Timing: filter latch sequence in ns and derived cycles at 25 ns clock
`define CGS_CLK_NS 25
`define CGS_LATCH_NS 50
`define CGS_LATCH_CYC ((`CGS_LATCH_NS + `CGS_CLK_NS - 1) / `CGS_CLK_NS)
`define CGS_UNLOCK_TOL 12'h004
`endif

// ===== logic/cgs_pkg.sv
// Types shared by the clock generator status and loop filter logic.
package cgs_pkg;
   // Clock modes as reported in the mode indicator and chosen by the mode select.
   typedef enum logic [1:0] {
      CGS_SELF = 2'b00,
      CGS_LOOP_INT = 2'b01,
      CGS_BYPASS_EXT = 2'b10,
      CGS_LOOP_EXT = 2'b11
   } cgs_mode_e;
   // Layout of the primary status register.
   typedef struct packed {
      cgs_mode_e clockModeIndicator;
      logic referenceKindIndicator;
      logic lockLossSticky;
      logic lockBit;
      logic clockLossSticky;
      logic extReferenceGood;
      logic clockgenIrqFlag;
   } cgs_stat1_s;
   // Samples delivered by the loop counter on the system clock.
   typedef struct packed {
      logic sample;
      logic [11:0] countError;
      logic oscStatic;
      logic filterValid;
      logic [11:0] filterValue;
   } cgs_loop_s;
endpackage

// ===== logic/cgs_status_flt.sv
// Status, interrupt flag and loop filter registers of the clock generator, with an APB slave.
//
// Overview of operation
// - mode indicator bits 7:6 report active mode.
// - mode indicator follows mode only after synchronisation.
// - bit 5 shows reference kind in use.
// - bit 4 sticky lock loss until cleared.
// - bit 3 lock, forced low outside engaged modes.
// - bit 2 sticky clock loss until cleared.
// - bit 1 shows external reference good.
// - bit 0 irq flag; read then write-one clears.
// - new interrupt restarts clear sequence.
// - writing zero to irq flag does nothing.
// - settled after two small error changes, not static.
// - off exit to X1 waits for settled.
// - settled bit cleared on entering off.
// - filter writable only when select is self-clocked.
// - upper write commits all twelve filter bits.
// - upper write ignored while latch still busy.
// - lock loss raises irq or reset by choice.
// - clock loss raises irq or reset by choice.
// - detect-off control disables clock loss detection.
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "cgs_defs.svh"

module cgs_status_flt
   import cgs_pkg::*;
#(
   parameter int LATCH_CYC = `CGS_LATCH_CYC, // Cycles of one filter latch sequence.
   parameter logic [11:0] UNLOCK_TOL = `CGS_UNLOCK_TOL // Error change tolerance.
) (
   input wire logic clk, // System clock, 40 MHz.
   input wire logic srst, // Synchronous reset, active high.
   input wire logic psel, // APB select.
   input wire logic penable, // APB enable.
   input wire logic pwrite, // APB direction, high for write.
   input wire logic [11:0] paddr, // APB byte address.
   input wire logic [31:0] pwdata, // APB write data.
   output logic [31:0] prdata, // APB read data.
   output logic pready, // APB ready.
   output logic pslverr, // APB error on unmapped address.
   input wire logic [1:0] activeModeIn, // Active mode from the mode machine, other domain.
   input wire logic refKindIn, // Reference kind in use, other domain.
   input wire logic loopLockedIn, // Loop lock detector level, other domain.
   input wire logic lockLostIn, // Unexpected lock loss level, other domain.
   input wire logic clockLostIn, // Clock loss detector level, other domain.
   input wire logic extRefGoodIn, // External reference good level, other domain.
   input wire logic offStateIn, // Generator is in the off state, other domain.
   input cgs_loop_s loopIn, // Loop counter samples, system clock.
   output logic [1:0] clockModeSelect, // Requested mode to the mode machine.
   output logic [11:0] loopFilterValue, // Filter value driving the oscillator.
   output logic filterLoad, // Pulse while a filter latch sequence starts.
   output logic oscillatorSettled, // Oscillator settled level.
   output logic monitorStart, // Start oscillator monitoring in self-clocked mode.
   output logic offExitGo, // Pulse allowing switch to requested mode after off.
   output logic clockLossDetectOff, // Clock loss detection disabled.
   output logic irqReq, // Interrupt request level.
   output logic resetReq // Reset request level.
);

   // ======================================================================
   // Input synchronisers
   // All levels from the oscillator and mode domains pass two flip-flops.
   localparam int SYNC_W = 8; // Number of synchronised level bits.
   logic [SYNC_W-1:0] syncIn; // Raw asynchronous levels.
   logic [SYNC_W-1:0] syncA_r; // First synchroniser stage.
   logic [SYNC_W-1:0] syncB_r; // Second synchroniser stage.

   assign syncIn = {offStateIn, extRefGoodIn, clockLostIn, lockLostIn, loopLockedIn,
                    refKindIn, activeModeIn};

   // Each bit of the group gets its own two-stage synchroniser.
   genvar gi;
   generate
      for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
         always_ff @(posedge clk) begin
            if (srst) begin
               syncA_r[gi] <= 1'b0;
               syncB_r[gi] <= 1'b0;
            end else begin
               syncA_r[gi] <= syncIn[gi];
               syncB_r[gi] <= syncA_r[gi];
            end
         end
      end
   endgenerate

   logic [1:0] modeSync; // Synchronised active mode.
   logic refKindSync; // Synchronised reference kind.
   logic lockedSync; // Synchronised lock level.
   logic lockLostSync; // Synchronised lock loss level.
   logic clockLostSync; // Synchronised clock loss level.
   logic extGoodSync; // Synchronised external reference good.
   logic offSync; // Synchronised off state.

   assign modeSync = syncB_r[1:0];
   assign refKindSync = syncB_r[2];
   assign lockedSync = syncB_r[3];
   assign lockLostSync = syncB_r[4];
   assign clockLostSync = syncB_r[5];
   assign extGoodSync = syncB_r[6];
   assign offSync = syncB_r[7];

   // ======================================================================
   // Edge detection and mode indicator
   logic lockLostPrev_r; // Previous lock loss level.
   logic clockLostPrev_r; // Previous clock loss level.
   logic offPrev_r; // Previous off level.
   logic [1:0] modePrev_r; // Previous synchronised mode, for a stability check.
   cgs_mode_e modeInd_r; // Mode shown in the status register.

   // Edge history of the synchronised levels.
   always_ff @(posedge clk) begin
      if (srst) begin
         lockLostPrev_r <= 1'b0;
         clockLostPrev_r <= 1'b0;
         offPrev_r <= 1'b0;
         modePrev_r <= 2'b00;
      end else begin
         lockLostPrev_r <= lockLostSync;
         clockLostPrev_r <= clockLostSync;
         offPrev_r <= offSync;
         modePrev_r <= modeSync;
      end
   end

   logic lockLostEvt; // Rising edge of lock loss.
   logic clockLostEvt; // Rising edge of clock loss, when detection is enabled.
   logic offEntry; // Generator just entered off.
   logic offExit; // Generator just left off.

   assign lockLostEvt = lockLostSync & ~lockLostPrev_r;
   assign clockLostEvt = clockLostSync & ~clockLostPrev_r & ~clockLossDetectOff;
   assign offEntry = offSync & ~offPrev_r;
   assign offExit = ~offSync & offPrev_r;

   // The two mode bits may be skewed by the crossing, so the indicator only
   // takes a value that held for two samples; it therefore lags the active mode input.
   always_ff @(posedge clk) begin
      if (srst) begin
         modeInd_r <= CGS_SELF;
      end else if (modeSync == modePrev_r) begin
         modeInd_r <= cgs_mode_e'(modeSync);
      end
   end

   // ======================================================================
   // APB decode
   logic setupPh; // Setup cycle of a transfer.
   logic accessPh; // Access cycle; the slave is always ready.
   logic wrAcc; // Write taking effect this edge.
   logic rdAcc; // Read completing this edge.
   logic hitStat1; // Address is the primary status register.
   logic hitStat2; // Address is the secondary status register.
   logic hitFltU; // Address is the upper filter register.
   logic hitFltL; // Address is the lower filter register.
   logic hitCtrl; // Address is the control register.
   logic hitAny; // Address maps to some register.

   assign setupPh = psel & ~penable;
   assign accessPh = psel & penable;
   assign wrAcc = accessPh & pwrite & hitAny;
   assign rdAcc = accessPh & ~pwrite & hitAny;
   assign hitStat1 = (paddr == `CGS_OFS_STAT1);
   assign hitStat2 = (paddr == `CGS_OFS_STAT2);
   assign hitFltU = (paddr == `CGS_OFS_FLTU);
   assign hitFltL = (paddr == `CGS_OFS_FLTL);
   assign hitCtrl = (paddr == `CGS_OFS_CTRL);
   assign hitAny = hitStat1 | hitStat2 | hitFltU | hitFltL | hitCtrl;
   assign pready = 1'b1;
   assign pslverr = accessPh & ~hitAny;

   // ======================================================================
   // Control register: mode select, action choices and detect disable
   logic [4:0] ctrl_r; // Control bits.

   // Software writes the control register at the access edge.
   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl_r <= `CGS_RST_CTRL;
      end else if (wrAcc && hitCtrl) begin
         ctrl_r <= pwdata[4:0];
      end
   end

   logic lockLossResetChoice; // High: lock loss requests a reset.
   logic clockLossResetChoice; // High: clock loss requests a reset.

   assign clockModeSelect = ctrl_r[1:0];
   assign lockLossResetChoice = ctrl_r[`CGS_BIT_LOLCHOICE];
   assign clockLossResetChoice = ctrl_r[`CGS_BIT_LOCCHOICE];
   assign clockLossDetectOff = ctrl_r[`CGS_BIT_LOCDOFF];

   // ======================================================================
   // Sticky loss flags; a write of one clears, a new event wins the same edge
   logic lockLossSticky_r; // Loop lost lock since last cleared.
   logic clockLossSticky_r; // Generator lost clock since last cleared.
   logic stickyWr; // Write to the primary status register.

   assign stickyWr = wrAcc & hitStat1;

   // Lock loss sticky flag.
   always_ff @(posedge clk) begin
      if (srst) begin
         lockLossSticky_r <= 1'b0;
      end else if (lockLostEvt) begin
         lockLossSticky_r <= 1'b1;
      end else if (stickyWr && pwdata[`CGS_BIT_LOCKLOSS]) begin
         lockLossSticky_r <= 1'b0;
      end
   end

   // Clock loss sticky flag.
   always_ff @(posedge clk) begin
      if (srst) begin
         clockLossSticky_r <= 1'b0;
      end else if (clockLostEvt) begin
         clockLossSticky_r <= 1'b1;
      end else if (stickyWr && pwdata[`CGS_BIT_CLKLOSS]) begin
         clockLossSticky_r <= 1'b0;
      end
   end

   // Each sticky flag that is set requests a reset when its choice says so.
   assign resetReq = (lockLossSticky_r & lockLossResetChoice) |
                     (clockLossSticky_r & clockLossResetChoice);

   // ======================================================================
   // Interrupt flag with read-then-write-one clearing
   logic irqFlag_r; // Pending generator interrupt.
   logic clrArmed_r; // Status was read with the flag set.
   logic irqEvt; // A new interrupt request this cycle.

   assign irqEvt = (lockLostEvt & ~lockLossResetChoice) |
                   (clockLostEvt & ~clockLossResetChoice);

   // Arming: a read of the primary status with the flag set arms the clear;
   // a new interrupt disarms it so the earlier clear cannot drop it.
   always_ff @(posedge clk) begin
      if (srst) begin
         clrArmed_r <= 1'b0;
      end else if (irqEvt) begin
         clrArmed_r <= 1'b0;
      end else if (rdAcc && hitStat1 && irqFlag_r) begin
         clrArmed_r <= 1'b1;
      end else if (stickyWr && pwdata[`CGS_BIT_IRQ]) begin
         clrArmed_r <= 1'b0;
      end
   end

   // Flag update; the set wins over a clear on the same edge.
   always_ff @(posedge clk) begin
      if (srst) begin
         irqFlag_r <= 1'b0;
      end else if (irqEvt) begin
         irqFlag_r <= 1'b1;
      end else if (stickyWr && pwdata[`CGS_BIT_IRQ] && clrArmed_r) begin
         irqFlag_r <= 1'b0;
      end
   end

   assign irqReq = irqFlag_r;

   // ======================================================================
   // Oscillator settled detection
   logic [11:0] prevErr_r; // Count error of the previous sample.
   logic [1:0] calmCnt_r; // Consecutive samples within tolerance.
   logic settled_r; // Oscillator settled.
   logic [11:0] errDelta; // Absolute change of the count error.

   assign errDelta = (loopIn.countError >= prevErr_r) ? loopIn.countError - prevErr_r :
                     prevErr_r - loopIn.countError;

   // Count samples whose error moved no more than the tolerance.
   always_ff @(posedge clk) begin
      if (srst || offEntry) begin
         prevErr_r <= 12'h000;
         calmCnt_r <= 2'h0;
      end else if (loopIn.sample) begin
         prevErr_r <= loopIn.countError;
         if (errDelta > UNLOCK_TOL || loopIn.oscStatic) begin
            calmCnt_r <= 2'h0;
         end else if (calmCnt_r != 2'h2) begin
            calmCnt_r <= calmCnt_r + 2'h1;
         end
      end
   end

   // The settled bit drops on entry to off and rises after two calm samples.
   always_ff @(posedge clk) begin
      if (srst || offEntry) begin
         settled_r <= 1'b0;
      end else begin
         settled_r <= (calmCnt_r == 2'h2) & ~loopIn.oscStatic;
      end
   end

   assign oscillatorSettled = settled_r;

   // ======================================================================
   // Off exit hold-off
   logic offWait_r; // Waiting for the oscillator after leaving off.
   logic offGo_r; // One-cycle release to the requested mode.

   // Leaving off with an engaged select waits for the settled bit.
   always_ff @(posedge clk) begin
      if (srst) begin
         offWait_r <= 1'b0;
         offGo_r <= 1'b0;
      end else begin
         offGo_r <= 1'b0;
         if (offEntry) begin
            offWait_r <= 1'b0;
         end else if (offExit && clockModeSelect[0]) begin
            offWait_r <= 1'b1;
         end else if (offWait_r && settled_r) begin
            offWait_r <= 1'b0;
            offGo_r <= 1'b1;
         end
      end
   end

   assign offExitGo = offGo_r;
   assign monitorStart = settled_r & (modeInd_r == CGS_SELF);

   // ======================================================================
   // Loop filter value and latch sequence
   logic [11:0] filter_r; // Current filter value.
   logic [7:0] lowStage_r; // Staged lower byte.
   logic [7:0] latchCnt_r; // Remaining cycles of the latch sequence.
   logic selfSel; // Select field asks for self-clocked mode.
   logic latchBusy; // Previous latch sequence still running.
   logic commit; // Upper write accepted this edge.

   assign selfSel = (clockModeSelect == CGS_SELF);
   assign latchBusy = (latchCnt_r != 8'h00);
   assign commit = wrAcc & hitFltU & selfSel & ~latchBusy;

   // Lower byte writes are staged only in self-clocked select.
   always_ff @(posedge clk) begin
      if (srst) begin
         lowStage_r <= 8'h00;
      end else if (wrAcc && hitFltL && selfSel) begin
         lowStage_r <= pwdata[7:0];
      end
   end

   // An accepted upper write loads all twelve bits; otherwise the loop updates it outside self-clocked select.
   always_ff @(posedge clk) begin
      if (srst) begin
         filter_r <= `CGS_RST_FILTER;
      end else if (commit) begin
         filter_r <= {pwdata[3:0], lowStage_r};
      end else if (loopIn.filterValid && !selfSel) begin
         filter_r <= loopIn.filterValue;
      end
   end

   // The latch sequence keeps later upper writes out until it ends.
   always_ff @(posedge clk) begin
      if (srst) begin
         latchCnt_r <= 8'h00;
      end else if (commit) begin
         latchCnt_r <= 8'(LATCH_CYC);
      end else if (latchBusy) begin
         latchCnt_r <= latchCnt_r - 8'h01;
      end
   end

   // Load strobe to the oscillator, one cycle after the commit.
   always_ff @(posedge clk) begin
      if (srst) begin
         filterLoad <= 1'b0;
      end else begin
         filterLoad <= commit;
      end
   end

   assign loopFilterValue = filter_r;

   // ======================================================================
   // Read data
   cgs_stat1_s stat1; // Primary status as read.
   logic [31:0] rdMux; // Read value for the addressed register.

   // Lock shows only in the two engaged modes and never in off.
   always_comb begin
      stat1.clockModeIndicator = modeInd_r;
      stat1.referenceKindIndicator = refKindSync;
      stat1.lockLossSticky = lockLossSticky_r;
      stat1.lockBit = lockedSync & modeInd_r[0] & ~offSync;
      stat1.clockLossSticky = clockLossSticky_r;
      stat1.extReferenceGood = extGoodSync;
      stat1.clockgenIrqFlag = irqFlag_r;
   end

   // Select the word; unmapped addresses read zero.
   always_comb begin
      rdMux = 32'h0000_0000;
      if (hitStat1) begin
         rdMux[7:0] = stat1;
      end else if (hitStat2) begin
         rdMux[`CGS_BIT_SETTLED] = settled_r;
      end else if (hitFltU) begin
         rdMux[3:0] = filter_r[11:8];
      end else if (hitFltL) begin
         rdMux[7:0] = filter_r[7:0];
      end else if (hitCtrl) begin
         rdMux[4:0] = ctrl_r;
      end
   end

   // Read data is captured in the setup cycle and stands through the access.
   always_ff @(posedge clk) begin
      if (srst) begin
         prdata <= 32'h0000_0000;
      end else if (setupPh) begin
         prdata <= rdMux;
      end
   end

endmodule

// ===== tb/cgs_status_flt_asserts.sv
// Assertions on the ports of the clock generator status block.
`timescale 1ns/10ps
module cgs_status_flt_asserts
   import cgs_pkg::*;
(
   input wire logic clk, // Clock.
   input wire logic srst, // Reset.
   input wire logic psel, // Select.
   input wire logic penable, // Enable.
   input wire logic pwrite, // Write.
   input wire logic [11:0] paddr, // Address.
   input wire logic [31:0] pwdata, // Write data.
   input wire logic lockLostIn, // Lock loss.
   input wire logic clockLostIn, // Clock loss.
   input wire logic offStateIn, // Off state.
   input cgs_loop_s loopIn, // Loop samples.
   input wire logic [1:0] clockModeSelect, // Mode select.
   input wire logic [11:0] loopFilterValue, // Filter value.
   input wire logic filterLoad, // Filter load.
   input wire logic oscillatorSettled, // Settled.
   input wire logic monitorStart, // Monitor start.
   input wire logic clockLossDetectOff, // Detect off.
   input wire logic irqReq, // Interrupt.
   input wire logic resetReq // Reset request.
);
   // ==========================
   // Bus write decode shared by the properties below.
   wire logic busWr = psel && penable && pwrite;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   filter_guard_a: assert property ($changed(loopFilterValue) |->
      $past(loopIn.filterValid) || $past(busWr && paddr == 12'h008 && clockModeSelect == 2'h0))
      else $error("filter moved without cause");
   filter_load_a: assert property (filterLoad |->
      $past(busWr && paddr == 12'h008 && clockModeSelect == 2'h0)) else $error("stray load");
   filter_busy_a: assert property (filterLoad |=> !filterLoad ##1
      $stable(loopFilterValue)) else $error("filter moved while busy");
   irq_raise_a: assert property ($rose(irqReq) |-> $past(lockLostIn) ||
      $past(clockLostIn && !clockLossDetectOff)) else $error("irq without event");
   reset_req_a: assert property ($rose(resetReq) |-> $past(lockLostIn || clockLostIn) ||
      $past(busWr && paddr == 12'h010)) else $error("reset request without event");
   irq_fall_a: assert property ($fell(irqReq) |->
      $past(busWr && paddr == 12'h000 && pwdata[0])) else $error("irq dropped without write");
   irq_keep_a: assert property (irqReq && !busWr |=> irqReq) else $error("irq lost");
   off_clear_a: assert property ($rose(offStateIn) |-> ##[1:5] !oscillatorSettled)
      else $error("settled kept in off");
   monitor_a: assert property (monitorStart |-> oscillatorSettled)
      else $error("monitor before settled");
   settle_rise_a: assert property ($rose(oscillatorSettled) |-> !$past(loopIn.oscStatic))
      else $error("settled on static clock");
endmodule
bind cgs_status_flt cgs_status_flt_asserts chk (.clk, .srst, .psel, .penable, .pwrite, .paddr,
   .pwdata, .lockLostIn, .clockLostIn, .offStateIn, .loopIn, .clockModeSelect, .loopFilterValue,
   .filterLoad, .oscillatorSettled, .monitorStart, .clockLossDetectOff, .irqReq, .resetReq);

// ===== tb/tb_top.sv
// Self-checking bench for the clock generator status and loop filter block.
`timescale 1ns/10ps
module tb_top;
   import cgs_pkg::*;
   logic clk = 1'h0; // System clock.
   logic srst = 1'h1; // Reset.
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0; // Bus controls.
   logic [11:0] paddr = 12'h000; // Bus address.
   logic [31:0] pwdata = 32'h0, prdata, rd; // Bus data and last read.
   logic pready, pslverr, err; // Bus answer and last error.
   logic [1:0] activeModeIn = 2'h0, clockModeSelect; // Modes.
   logic refKindIn = 1'h0, loopLockedIn = 1'h0, lockLostIn = 1'h0, clockLostIn = 1'h0;
   logic extRefGoodIn = 1'h0, offStateIn = 1'h0; // Status levels.
   cgs_loop_s loopIn = '0; // Loop samples.
   logic [11:0] loopFilterValue; // Filter value.
   logic filterLoad, oscillatorSettled, monitorStart, offExitGo, clockLossDetectOff;
   logic irqReq, resetReq; // Requests.
   int error_cnt = 0, cmp_count = 0, goCnt = 0; // Counters.
   always #12.5 clk = ~clk;
   cgs_status_flt dut (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .activeModeIn, .refKindIn, .loopLockedIn, .lockLostIn, .clockLostIn,
      .extRefGoodIn, .offStateIn, .loopIn, .clockModeSelect, .loopFilterValue, .filterLoad,
      .oscillatorSettled, .monitorStart, .offExitGo, .clockLossDetectOff, .irqReq, .resetReq);
   // Counts release pulses after off exit.
   always @(posedge clk) begin
      if (offExitGo === 1'h1) goCnt <= goCnt + 1;
   end
   // ==========================
   // Compares one value and counts it.
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // One APB transfer; keep leaves select up for a back-to-back follower.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      input bit keep = 0);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      @(posedge clk);
      while (pready !== 1'h1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      if (!keep) begin
         psel <= 1'h0;
         penable <= 1'h0;
         @(posedge clk);
      end
   endtask
   // Waits whole cycles.
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Delivers one loop sample.
   task automatic samp(input logic [11:0] e);
      loopIn.countError <= e;
      loopIn.sample <= 1'h1;
      @(posedge clk);
      loopIn.sample <= 1'h0;
      @(posedge clk);
   endtask
   // ==========================
   // Reset values, and an unmapped address.
   task automatic t_reset;
      for (int i = 0; i < 6; i++) begin
         apb(1'h0, 12'(i * 4), 32'h0);
         chk("reset value", 32'h0, rd);
      end
      chk("unmapped", 32'h1, {31'h0, err});
      $display("reset test done");
   endtask
   // Every mode with its lag, reference kind, lock and reference good.
   task automatic t_status;
      logic [1:0] m, prev;
      prev = 2'h0;
      for (int i = 0; i < 4; i++) begin
         m = 2'(i);
         activeModeIn <= m;
         refKindIn <= m[1];
         extRefGoodIn <= m[0];
         loopLockedIn <= 1'h1;
         apb(1'h0, 12'h000, 32'h0);
         chk("mode lag", {30'h0, prev}, {30'h0, rd[7:6]});
         wt(8);
         apb(1'h0, 12'h000, 32'h0);
         chk("status", {24'h0, m, m[1], 1'h0, m[0], 1'h0, m[0], 1'h0}, rd);
         prev = m;
      end
      activeModeIn <= 2'h0;
      $display("status test done");
   endtask
   // Clock loss interrupt and its clearing sequence.
   task automatic t_irq;
      apb(1'h1, 12'h010, 32'h0);
      clockLostIn <= 1'h1;
      wt(8);
      chk("irq raised", 32'h1, {31'h0, irqReq});
      apb(1'h1, 12'h000, 32'h1);
      chk("irq unarmed", 32'h1, {31'h0, irqReq});
      apb(1'h0, 12'h000, 32'h0);
      chk("flags", 32'h5, rd & 32'h5);
      apb(1'h1, 12'h000, 32'h0);
      chk("irq zero write", 32'h1, {31'h0, irqReq});
      clockLostIn <= 1'h0;
      wt(4);
      clockLostIn <= 1'h1;
      wt(8);
      apb(1'h1, 12'h000, 32'h1);
      chk("irq restart", 32'h1, {31'h0, irqReq});
      apb(1'h0, 12'h000, 32'h0);
      apb(1'h1, 12'h000, 32'h5);
      chk("irq cleared", 32'h0, {31'h0, irqReq});
      apb(1'h0, 12'h000, 32'h0);
      chk("flags clear", 32'h0, rd & 32'h5);
      clockLostIn <= 1'h0;
      $display("interrupt test done");
   endtask
   // Lock loss with the reset choice.
   task automatic t_resreq;
      apb(1'h1, 12'h010, 32'hc);
      lockLostIn <= 1'h1;
      wt(8);
      chk("reset req", 32'h1, {31'h0, resetReq});
      chk("no irq", 32'h0, {31'h0, irqReq});
      lockLostIn <= 1'h0;
      wt(6);
      apb(1'h0, 12'h000, 32'h0);
      chk("lock loss sticky", 32'h10, rd & 32'h10);
      apb(1'h1, 12'h000, 32'h10);
      chk("reset req off", 32'h0, {31'h0, resetReq});
      $display("lock loss test done");
   endtask
   // Clock loss ignored with detection off.
   task automatic t_detect;
      apb(1'h1, 12'h010, 32'h10);
      chk("detect off", 32'h1, {31'h0, clockLossDetectOff});
      clockLostIn <= 1'h1;
      wt(8);
      apb(1'h0, 12'h000, 32'h0);
      chk("no clock loss", 32'h0, rd & 32'h5);
      clockLostIn <= 1'h0;
      apb(1'h1, 12'h010, 32'h0);
      $display("detect test done");
   endtask
   // Filter staging, commit, busy refusal and mode lock.
   task automatic t_filter;
      apb(1'h1, 12'h00c, 32'h5a);
      chk("lower alone", 32'h0, {20'h0, loopFilterValue});
      apb(1'h1, 12'h008, 32'h3, 1);
      apb(1'h1, 12'h008, 32'hf);
      chk("filter busy", 32'h35a, {20'h0, loopFilterValue});
      wt(4);
      apb(1'h1, 12'h008, 32'hf);
      chk("filter commit", 32'hf5a, {20'h0, loopFilterValue});
      apb(1'h1, 12'h010, 32'h1);
      apb(1'h1, 12'h00c, 32'h12);
      apb(1'h1, 12'h008, 32'h1);
      chk("filter locked", 32'hf5a, {20'h0, loopFilterValue});
      apb(1'h0, 12'h008, 32'h0);
      chk("upper read", 32'hf, rd);
      apb(1'h0, 12'h00c, 32'h0);
      chk("lower read", 32'h5a, rd);
      $display("filter test done");
   endtask
   // Settling, off entry and the wait on off exit.
   task automatic t_settle;
      samp(12'h002);
      samp(12'h004);
      wt(3);
      chk("settled", 32'h1, {31'h0, oscillatorSettled});
      apb(1'h0, 12'h004, 32'h0);
      chk("status2", 32'h1, rd);
      offStateIn <= 1'h1;
      wt(6);
      chk("off clears", 32'h0, {31'h0, oscillatorSettled});
      offStateIn <= 1'h0;
      wt(6);
      chk("exit waits", 32'h0, 32'(goCnt));
      samp(12'h002);
      samp(12'h004);
      wt(4);
      chk("exit go", 32'h1, 32'(goCnt));
      $display("settle test done");
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Main sequence.
   initial begin
      repeat (4) @(posedge clk);
      srst <= 1'h0;
      @(posedge clk);
      t_reset;
      t_status;
      t_irq;
      t_resreq;
      t_detect;
      t_filter;
      t_settle;
      close_out;
   end
   // Watchdog against a hung handshake.
   initial begin
      repeat (5000) @(posedge clk);
      error_cnt++;
      close_out;
   end
endmodule
